/* File: sar_alarm_bank.sv */
// alarm and reference status readback registers with alarm mask
//
// Function
// - alarm summary byte bit0 is combined alarm
// - alarm when any masked status condition active
// - detail bit2 shows output phase stable
// - detail bit1 high until first sync event
// - status bit4 busy when any channel requests clock while running
// - status bits3..0 show reseed step code
// - reseed steps follow one of three sequences
`timescale 1ns/10ps
module sar_alarm_bank
  import sar_pkg::*;
#(
  parameter int NUM_CH = SAR_NUM_CH
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [SAR_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic reg_wr_en,
  input wire logic [SAR_DATA_W-1:0] reg_wdata,
  output logic [SAR_DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_unmapped,
  output logic reg_wr_ignored,
  // status from sync and pulse logic
  input sar_status_t status_in,
  // reseed triggers
  input sar_trigger_t reseed_trig,
  // channel state machines
  input wire logic [NUM_CH-1:0] ch_clk_req,
  input wire logic [NUM_CH-1:0] ch_running,
  // combined alarm
  output logic alarm
);

  // ==========================================================================
  // register select, one code per decoded byte
  typedef enum logic [2:0] {
    sel_mask,
    sel_summary,
    sel_detail,
    sel_spare,
    sel_fsm,
    sel_none
  } sar_sel_t;

  sar_bank_reg_t r;
  sar_bank_reg_t next_r;
  sar_sel_t reg_sel;
  logic [3:0] step_code;
  logic [NUM_CH-1:0] ch_busy;
  logic any_busy;
  logic sync_seen;
  logic alarm_cond;

  // ==========================================================================
  // reseed sequencer
  sar_reseed_fsm sar_reseed_fsm_inst (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .trig(reseed_trig),
    .step_code(step_code)
  );

  // ==========================================================================
  // channel busy
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign ch_busy[gi] = ch_clk_req[gi] & ch_running[gi];
    end
  endgenerate
  assign any_busy = |ch_busy;

  // ==========================================================================
  // address decode, shared by the read and write paths
  function automatic sar_sel_t decode_addr(input logic [SAR_ADDR_W-1:0] a);
    sar_sel_t s;
    s = sel_none;
    if (a == SAR_ADDR_ALARM_MASK) begin
      s = sel_mask;
    end else if (a == SAR_ADDR_ALARM_SUMMARY) begin
      s = sel_summary;
    end else if (a == SAR_ADDR_ALARM_DETAIL) begin
      s = sel_detail;
    end else if (a == SAR_ADDR_ALARM_SPARE) begin
      s = sel_spare;
    end else if (a == SAR_ADDR_REF_FSM_STATUS) begin
      s = sel_fsm;
    end
    decode_addr = s;
  endfunction

  assign reg_sel = decode_addr(reg_addr);

  // ==========================================================================
  // byte assembly
  function automatic logic [7:0] summary_byte(input logic al);
    logic [7:0] b;
    b = 8'h00;
    b[SAR_SUMMARY_ALARM_BIT] = al;
    summary_byte = b;
  endfunction

  function automatic logic [7:0] detail_byte(input sar_status_t st, input logic never);
    logic [7:0] b;
    b = 8'h00;
    b[SAR_DETAIL_SYNC_REQ_BIT] = st.sync_req;
    b[SAR_DETAIL_PHASE_BIT] = st.phase_valid;
    b[SAR_DETAIL_NEVER_SYNC_BIT] = never;
    detail_byte = b;
  endfunction

  function automatic logic [7:0] fsm_byte(input logic bsy, input logic [3:0] code);
    logic [7:0] b;
    b = 8'h00;
    b[SAR_FSM_BUSY_BIT] = bsy;
    b[SAR_FSM_CODE_LSB +: SAR_FSM_CODE_W] = code;
    fsm_byte = b;
  endfunction

  // ==========================================================================
  // alarm combination
  assign sync_seen = status_in.ext_sync | status_in.spi_sync;
  always_comb begin
    alarm_cond = 1'b0;
    if (r.mask[SAR_MASK_SYNC_REQ_BIT] && status_in.sync_req) begin
      alarm_cond = 1'b1;
    end
    if (r.mask[SAR_MASK_PHASE_BIT] && !status_in.phase_valid) begin
      alarm_cond = 1'b1;
    end
    if (r.mask[SAR_MASK_REF_SYNC_BIT] && r.never_synced) begin
      alarm_cond = 1'b1;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.rd_valid = 1'b0;
    next_r.wr_ignored = 1'b0;
    // history clears on the first sync and never sets again
    if (sync_seen) begin
      next_r.never_synced = 1'b0;
    end
    next_r.busy = any_busy;
    next_r.alarm = alarm_cond;

    // read decode, answered one cycle later; a write in the same
    // cycle lands after the read has taken the old mask
    if (reg_rd_en) begin
      next_r.rd_valid = 1'b1;
      next_r.rd_unmapped = 1'b0;
      case (reg_sel)
        sel_mask: begin
          next_r.rd_data = r.mask;
        end
        sel_summary: begin
          next_r.rd_data = summary_byte(r.alarm);
        end
        sel_detail: begin
          next_r.rd_data = detail_byte(status_in, r.never_synced);
        end
        sel_spare: begin
          next_r.rd_data = SAR_DATA_RESET;
        end
        sel_fsm: begin
          next_r.rd_data = fsm_byte(r.busy, step_code);
        end
        default: begin
          // unknown address: zero data, flag stands until the next read
          next_r.rd_data = SAR_DATA_RESET;
          next_r.rd_unmapped = 1'b1;
        end
      endcase
    end

    // write decode: only the mask holds storage
    if (reg_wr_en) begin
      if (reg_sel == sel_mask) begin
        // reserved mask bits cannot be set
        next_r.mask = reg_wdata & SAR_MASK_WRITABLE;
      end else begin
        next_r.wr_ignored = 1'b1;
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r.mask <= SAR_MASK_RESET;
      r.never_synced <= SAR_NEVER_SYNC_RESET;
      r.busy <= 1'b0;
      r.alarm <= 1'b0;
      r.rd_data <= SAR_DATA_RESET;
      r.rd_valid <= 1'b0;
      r.rd_unmapped <= 1'b0;
      r.wr_ignored <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata = r.rd_data;
  assign reg_rvalid = r.rd_valid;
  assign reg_unmapped = r.rd_unmapped;
  assign reg_wr_ignored = r.wr_ignored;
  assign alarm = r.alarm;

endmodule

/* File: sar_alarm_bank_props.sv */
// assertion checker for the alarm status readback ports
`timescale 1ns/10ps
module sar_alarm_bank_props
  import sar_pkg::*;
#(
  parameter int NUM_CH = SAR_NUM_CH
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [SAR_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic reg_wr_en,
  input wire logic [SAR_DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_unmapped,
  input wire logic reg_wr_ignored,
  // status and channels
  input sar_status_t status_in,
  input wire logic [NUM_CH-1:0] ch_clk_req,
  input wire logic [NUM_CH-1:0] ch_running,
  input wire logic alarm
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // read decodes
  logic rd_sum;
  logic rd_det;
  logic rd_fsm;
  logic rd_map;
  assign rd_sum = reg_rd_en && reg_addr == SAR_ADDR_ALARM_SUMMARY;
  assign rd_det = reg_rd_en && reg_addr == SAR_ADDR_ALARM_DETAIL;
  assign rd_fsm = reg_rd_en && reg_addr == SAR_ADDR_REF_FSM_STATUS;
  assign rd_map = reg_rd_en && !(reg_addr inside {SAR_ADDR_ALARM_MASK, SAR_ADDR_ALARM_SUMMARY,
    SAR_ADDR_ALARM_DETAIL, SAR_ADDR_ALARM_SPARE, SAR_ADDR_REF_FSM_STATUS});
  // ==========================================================================
  // properties
  property p_answer; reg_rd_en |=> reg_rvalid; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_quiet; !reg_rd_en |=> !reg_rvalid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without read");
  property p_summary; rd_sum |=> reg_rdata == {7'h00, $past(alarm)}; endproperty
  a_summary: assert property (p_summary) else $error("summary byte wrong");
  property p_phase; rd_det |=> reg_rdata[2] == $past(status_in.phase_valid)
    && reg_rdata[7:5] == 3'h0 && !reg_rdata[3] && !reg_rdata[0]; endproperty
  a_phase: assert property (p_phase) else $error("detail byte wrong");
  property p_synced; (status_in.ext_sync || status_in.spi_sync) ##2 rd_det |=> !reg_rdata[1];
  endproperty
  a_synced: assert property (p_synced) else $error("sync history not cleared");
  property p_busy; rd_fsm && $past(nrst) |=> reg_rdata[7:5] == 3'h0
    && reg_rdata[4] == $past(|(ch_clk_req & ch_running), 2); endproperty
  a_busy: assert property (p_busy) else $error("busy bit wrong");
  property p_code; rd_fsm |=> reg_rdata[3:0] inside {4'h0, 4'h2, 4'h4, 4'h5, 4'h6,
    4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf}; endproperty
  a_code: assert property (p_code) else $error("illegal step code");
  property p_unmapped; rd_map |=> reg_unmapped && reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");
  property p_wr_ign; reg_wr_en && reg_addr != SAR_ADDR_ALARM_MASK |=> reg_wr_ignored;
  endproperty
  a_wr_ign: assert property (p_wr_ign) else $error("write not ignored");
  c_busy: cover property (rd_fsm ##1 reg_rdata[4]);
  c_unmapped: cover property (rd_map);
  c_alarm: cover property ($rose(alarm));
endmodule

bind sar_alarm_bank sar_alarm_bank_props #(.NUM_CH(NUM_CH)) sar_alarm_bank_props_inst (
  .sys_clk, .nrst, .reg_addr, .reg_rd_en, .reg_wr_en, .reg_rdata, .reg_rvalid,
  .reg_unmapped, .reg_wr_ignored, .status_in, .ch_clk_req, .ch_running, .alarm
);

/* File: sar_alarm_bank_tb.sv */
// testbench for the alarm status readback block
`timescale 1ns/10ps
module sar_alarm_bank_tb;
  import sar_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  sar_status_t status_in = 4'h4;
  sar_trigger_t reseed_trig = '0;
  logic [SAR_NUM_CH-1:0] ch_clk_req = '0;
  logic [SAR_NUM_CH-1:0] ch_running = '0;
  logic [15:0] reg_addr;
  logic reg_rd_en;
  logic reg_wr_en;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic alarm;
  logic reg_unmapped;
  logic reg_wr_ignored;
  int ign_cnt = 0;
  int err_total = 0;
  int samples_checked = 0;
  always #10 sys_clk = ~sys_clk;
  sar_alarm_bank #(.NUM_CH(SAR_NUM_CH)) sar_alarm_bank_inst (
    .sys_clk, .nrst, .reg_addr, .reg_rd_en, .reg_wr_en, .reg_wdata, .reg_rdata,
    .reg_rvalid, .reg_unmapped, .reg_wr_ignored, .status_in, .reseed_trig,
    .ch_clk_req, .ch_running, .alarm
  );
  sar_host_model sar_host_model_inst (
    .sys_clk, .reg_addr, .reg_rd_en, .reg_wr_en, .reg_wdata, .reg_rdata, .reg_rvalid
  );
  // ignored-write pulses, counted mid-cycle while they stand
  always @(negedge sys_clk) begin
    if (reg_wr_ignored) begin
      ign_cnt++;
    end
  end
  // ==========================================================================
  // helpers
  task automatic finish_test();
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd1(input logic [15:0] a, input logic [7:0] exp);
    sar_host_model_inst.rd(a, 1);
    chk(sar_host_model_inst.q[0], exp);
    if (sar_host_model_inst.q.size() == 0) begin
      finish_test();
    end
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    sar_host_model_inst.wr(SAR_ADDR_ALARM_DETAIL, 8'hff);
    sar_host_model_inst.wr(SAR_ADDR_REF_FSM_STATUS, 8'hff);
    rd1(SAR_ADDR_ALARM_SUMMARY, 8'h00);
    rd1(SAR_ADDR_ALARM_DETAIL, 8'h06);
    rd1(SAR_ADDR_ALARM_SPARE, 8'h00);
    rd1(SAR_ADDR_REF_FSM_STATUS, 8'h00);
    rd1(16'h0050, 8'h00);
    chk({7'h00, reg_unmapped}, 8'h01);
    sar_host_model_inst.wr(SAR_ADDR_ALARM_MASK, 8'hff);
    rd1(SAR_ADDR_ALARM_MASK, 8'h16);
    chk({7'h00, reg_unmapped}, 8'h00);
    chk(8'(ign_cnt), 8'h02);
  endtask
  // mask, status, expected summary
  task automatic t_alarm();
    logic [19:0] tbl [6] = '{20'h04400, 20'h04001, 20'h10000, 20'h10801, 20'h02401,
      20'h02500};
    foreach (tbl[i]) begin
      sar_host_model_inst.wr(SAR_ADDR_ALARM_MASK, tbl[i][19:12]);
      status_in <= tbl[i][11:8];
      repeat (2) @(posedge sys_clk);
      rd1(SAR_ADDR_ALARM_SUMMARY, tbl[i][7:0]);
      chk({7'h00, alarm}, tbl[i][7:0]);
    end
    status_in <= 4'h4;
    rd1(SAR_ADDR_ALARM_DETAIL, 8'h04);
  endtask
  task automatic t_busy();
    ch_clk_req <= 14'h0008;
    ch_running <= 14'h2000;
    @(posedge sys_clk);
    rd1(SAR_ADDR_REF_FSM_STATUS, 8'h00);
    ch_clk_req <= 14'h2008;
    @(posedge sys_clk);
    rd1(SAR_ADDR_REF_FSM_STATUS, 8'h10);
    ch_running <= '0;
    @(posedge sys_clk);
  endtask
  // reseed, pulse generator and reserved progressions
  task automatic t_fsm();
    logic [31:0] exp [4] = '{32'h0fcdeb20, 32'h0456a200, 32'h0fb20000, 32'h0456aaa2};
    logic [3:0] trg [4] = '{4'h8, 4'h4, 4'h2, 4'h5};
    for (int i = 0; i < 4; i++) begin
      fork
        begin
          reseed_trig <= sar_trigger_t'(trg[i]);
          @(posedge sys_clk);
          // pulse_run alone holds the running step, it starts nothing
          reseed_trig <= sar_trigger_t'(trg[i] & 4'h1);
          repeat (5) @(posedge sys_clk);
          reseed_trig <= '0;
        end
        sar_host_model_inst.rd(SAR_ADDR_REF_FSM_STATUS, 8);
      join
      for (int k = 0; k < 8; k++) begin
        chk(sar_host_model_inst.q[k], {4'h0, exp[i][31-4*k -: 4]});
      end
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_alarm();
    t_busy();
    t_fsm();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end
endmodule

/* File: sar_host_model.sv */
// host model issuing register reads and writes
`timescale 1ns/10ps
module sar_host_model
  import sar_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // register port
  output logic [SAR_ADDR_W-1:0] reg_addr,
  output logic reg_rd_en,
  output logic reg_wr_en,
  output logic [SAR_DATA_W-1:0] reg_wdata,
  input wire logic [SAR_DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  logic [7:0] q[$];
  initial begin
    reg_addr = '0;
    reg_rd_en = 1'b0;
    reg_wr_en = 1'b0;
    reg_wdata = '0;
  end
  always @(negedge sys_clk) begin
    if (reg_rvalid) begin
      q.push_back(reg_rdata);
    end
  end
  // entered just after a rising edge; n reads back to back
  task automatic rd(input logic [15:0] a, input int n);
    q.delete();
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    repeat (n) @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    for (int k = 0; k < 4 && q.size() < n; k++) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge sys_clk);
  endtask
endmodule

/* File: sar_pkg.sv */
// constants, types and helpers shared by the alarm status readback block
package sar_pkg;

  // ==========================================================================
  // register port
  localparam int SAR_ADDR_W = 16;
  localparam int SAR_DATA_W = 8;
  localparam int SAR_NUM_CH = 14;

  localparam logic [15:0] SAR_ADDR_ALARM_MASK = 16'h0071;
  localparam logic [15:0] SAR_ADDR_ALARM_SUMMARY = 16'h007b;
  localparam logic [15:0] SAR_ADDR_ALARM_DETAIL = 16'h007d;
  localparam logic [15:0] SAR_ADDR_ALARM_SPARE = 16'h007f;
  localparam logic [15:0] SAR_ADDR_REF_FSM_STATUS = 16'h0091;

  // ==========================================================================
  // field positions
  localparam int SAR_MASK_SYNC_REQ_BIT = 4;
  localparam int SAR_MASK_PHASE_BIT = 2;
  localparam int SAR_MASK_REF_SYNC_BIT = 1;
  localparam int SAR_SUMMARY_ALARM_BIT = 0;
  localparam int SAR_DETAIL_SYNC_REQ_BIT = 4;
  localparam int SAR_DETAIL_PHASE_BIT = 2;
  localparam int SAR_DETAIL_NEVER_SYNC_BIT = 1;
  localparam int SAR_FSM_BUSY_BIT = 4;
  localparam int SAR_FSM_CODE_LSB = 0;
  localparam int SAR_FSM_CODE_W = 4;

  // ==========================================================================
  // reset values and writable mask bits
  localparam logic [7:0] SAR_MASK_RESET = 8'h00;
  localparam logic [7:0] SAR_MASK_WRITABLE = 8'h16;
  localparam logic [7:0] SAR_DATA_RESET = 8'h00;
  localparam logic SAR_NEVER_SYNC_RESET = 1'b1;

  // ==========================================================================
  // reseed step codes as reported
  localparam logic [3:0] SAR_CODE_RESET = 4'h0;
  localparam logic [3:0] SAR_CODE_DONE = 4'h2;
  localparam logic [3:0] SAR_CODE_GET_READY_0 = 4'h4;
  localparam logic [3:0] SAR_CODE_GET_READY_1 = 4'h5;
  localparam logic [3:0] SAR_CODE_GET_READY_2 = 4'h6;
  localparam logic [3:0] SAR_CODE_RUNNING = 4'ha;
  localparam logic [3:0] SAR_CODE_START = 4'hb;
  localparam logic [3:0] SAR_CODE_POWER_UP_0 = 4'hc;
  localparam logic [3:0] SAR_CODE_POWER_UP_1 = 4'hd;
  localparam logic [3:0] SAR_CODE_POWER_UP_2 = 4'he;
  localparam logic [3:0] SAR_CODE_CLEAR_RESET = 4'hf;

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    st_reset, st_done, st_get_ready_0, st_get_ready_1, st_get_ready_2, st_running,
    st_start, st_power_up_0, st_power_up_1, st_power_up_2, st_clear_reset
  } sar_fsm_state_t;

  typedef enum logic [1:0] {seq_reseed, seq_pulse, seq_rsvd} sar_seq_t;

  typedef struct packed {
    logic reseed;
    logic pulse_gen;
    logic rsvd;
    logic pulse_run;
  } sar_trigger_t;

  typedef struct packed {
    logic sync_req;
    logic phase_valid;
    logic ext_sync;
    logic spi_sync;
  } sar_status_t;

  typedef struct packed {
    sar_fsm_state_t state;
    sar_seq_t seq;
    logic [3:0] code;
  } sar_fsm_reg_t;

  typedef struct packed {
    logic [7:0] mask;
    logic never_synced;
    logic busy;
    logic alarm;
    logic [7:0] rd_data;
    logic rd_valid;
    logic rd_unmapped;
    logic wr_ignored;
  } sar_bank_reg_t;

  // ==========================================================================
  // helpers
  function automatic logic [3:0] sar_state_code(input sar_fsm_state_t s);
    case (s)
      st_reset: sar_state_code = SAR_CODE_RESET;
      st_done: sar_state_code = SAR_CODE_DONE;
      st_get_ready_0: sar_state_code = SAR_CODE_GET_READY_0;
      st_get_ready_1: sar_state_code = SAR_CODE_GET_READY_1;
      st_get_ready_2: sar_state_code = SAR_CODE_GET_READY_2;
      st_running: sar_state_code = SAR_CODE_RUNNING;
      st_start: sar_state_code = SAR_CODE_START;
      st_power_up_0: sar_state_code = SAR_CODE_POWER_UP_0;
      st_power_up_1: sar_state_code = SAR_CODE_POWER_UP_1;
      st_power_up_2: sar_state_code = SAR_CODE_POWER_UP_2;
      st_clear_reset: sar_state_code = SAR_CODE_CLEAR_RESET;
      default: sar_state_code = SAR_CODE_RESET;
    endcase
  endfunction

endpackage

/* File: sar_reseed_fsm.sv */
// reseed step sequencer with three trigger-dependent progressions
`timescale 1ns/10ps
module sar_reseed_fsm
  import sar_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // triggers
  input sar_trigger_t trig,
  // step code
  output logic [3:0] step_code
);

  sar_fsm_reg_t r;
  sar_fsm_reg_t next_r;

  // ==========================================================================
  // sequencing
  always_comb begin
    next_r = r;
    case (r.state)
      st_reset, st_done: begin
        // priority reseed, then pulse generator, then reserved
        if (trig.reseed) begin
          next_r.seq = seq_reseed;
          next_r.state = st_clear_reset;
        end else if (trig.pulse_gen) begin
          next_r.seq = seq_pulse;
          next_r.state = st_get_ready_0;
        end else if (trig.rsvd) begin
          next_r.seq = seq_rsvd;
          next_r.state = st_clear_reset;
        end else begin
          next_r.state = st_reset;
        end
      end
      st_clear_reset: begin
        if (r.seq == seq_rsvd) begin
          next_r.state = st_start;
        end else begin
          next_r.state = st_power_up_0;
        end
      end
      st_power_up_0: next_r.state = st_power_up_1;
      st_power_up_1: next_r.state = st_power_up_2;
      st_power_up_2: next_r.state = st_start;
      st_start: next_r.state = st_done;
      st_get_ready_0: next_r.state = st_get_ready_1;
      st_get_ready_1: next_r.state = st_get_ready_2;
      st_get_ready_2: next_r.state = st_running;
      st_running: begin
        // holds while the pulse generator keeps running
        if (!trig.pulse_run) begin
          next_r.state = st_done;
        end
      end
      default: next_r.state = st_reset;
    endcase
    next_r.code = sar_state_code(next_r.state);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r.state <= st_reset;
      r.seq <= seq_reseed;
      r.code <= SAR_CODE_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign step_code = r.code;

endmodule
